// *** core/dicc_pkg.sv ***
// shared constants for the idle-command and clock-change link
package dicc_pkg;
	// ************************************************************
	// command encodings {ras_n, cas_n, we_n}, sent with cs_n low; CMD_DES is {cs_n, ras_n, cas_n, we_n}
	// ************************************************************
	localparam logic [2:0] CMD_MODE_WR = 3'b000;
	localparam logic [2:0] CMD_REF  = 3'b001;
	localparam logic [2:0] CMD_PRE  = 3'b010;
	localparam logic [2:0] CMD_ACT  = 3'b011;
	localparam logic [2:0] CMD_WR   = 3'b100;
	localparam logic [2:0] CMD_RD   = 3'b101;
	localparam logic [2:0] CMD_NO_OP = 3'b111;
	localparam logic [3:0] CMD_DES  = 4'hf;
	// ************************************************************
	// mode register selects and address bit positions
	// ************************************************************
	localparam logic [2:0] BA_MR    = 3'h0;
	localparam logic [2:0] BA_EMR1  = 3'h1;
	localparam logic [2:0] BA_EMR2  = 3'h2;
	localparam int         DLL_RST_BIT           = 8;
	localparam int         HI_TEMP_SELF_REFRESH_BIT = 7;
	localparam int         ALL_BANKS_BIT         = 10;
	localparam int         ADDR_W   = 13;
	localparam int         BA_W     = 3;
	// ************************************************************
	// register map of the controller
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CKDIV  = 8'h04;
	localparam logic [7:0] REG_MODE   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int         CTRL_START = 0;
	localparam int         CTRL_HOT   = 1;
	localparam int         CTRL_HTS   = 2;
	localparam int         CTRL_MRUPD = 3;
	localparam int         CTRL_TERM  = 4;
	localparam logic [7:0] CKDIV_RST  = 8'h02;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int         CLK_PERIOD_PS  = 25000;
	localparam int         REFI_NORM_NS   = 7800;
	localparam int         REFI_HOT_NS    = 3900;
	localparam int         REFI_NORM_CYC  = (REFI_NORM_NS * 1000) / CLK_PERIOD_PS;
	localparam int         REFI_HOT_CYC   = (REFI_HOT_NS * 1000) / CLK_PERIOD_PS;
	localparam int         PD_WAIT_CK     = 2;
	localparam int         PRE_WAIT_CK    = 2;
	localparam int         STABLE_CK      = 4;
	localparam int         LOCK_CK        = 200;
	localparam int         BURST_CK       = 2;
endpackage

// *** core/dicc_link_if.sv ***
// link pins between controller and memory device
`timescale 1ns/10ps
interface dicc_link_if;
	logic        ck;
	logic        cke;
	logic        on_die_termination_ctl;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [12:0] addr;

	modport ctl (
		output ck,
		output cke,
		output on_die_termination_ctl,
		output cs_n,
		output ras_n,
		output cas_n,
		output we_n,
		output ba,
		output addr
	);
	modport mem (
		input  ck,
		input  cke,
		input  on_die_termination_ctl,
		input  cs_n,
		input  ras_n,
		input  cas_n,
		input  we_n,
		input  ba,
		input  addr
	);
endinterface

// *** core/dicc_mem.sv ***
// memory device end: command decode, power-down and dll state
`timescale 1ns/10ps
module dicc_mem #(
	parameter int LOCK_CK  = dicc_pkg::LOCK_CK,
	parameter int BURST_CK = dicc_pkg::BURST_CK
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	dicc_link_if.mem         link,
	output logic             cmd_seen,
	output logic [3:0]       cmd_code,
	output logic             in_pd,
	output logic             dll_locked,
	output logic             ready,
	output logic             burst_busy,
	output logic             hts_sr,
	output logic [12:0]      mode_q
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [22:0] s1_q;
	logic [22:0] s2_q;
	logic        ck_prev_q;
	logic        rise;
	logic        cke_s;
	logic [3:0]  cmd_s;
	logic [2:0]  ba_s;
	logic [12:0] addr_s;
	logic [7:0]  bank_open_q;
	logic [15:0] lock_cnt_q;
	logic [3:0]  burst_cnt_q;
	logic        idle_cmd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q      <= '0;
			s2_q      <= '0;
			ck_prev_q <= 1'b0;
		end else begin
			s1_q      <= {link.ck, link.cke, link.on_die_termination_ctl, link.cs_n,
			              link.ras_n, link.cas_n, link.we_n, link.ba, link.addr};
			s2_q      <= s1_q;
			ck_prev_q <= s2_q[22];
		end
	end

	assign rise   = s2_q[22] & ~ck_prev_q;
	assign cke_s  = s2_q[21];
	assign cmd_s  = s2_q[19:16];
	assign ba_s   = s2_q[15:13];
	assign addr_s = s2_q[12:0];
	assign idle_cmd = cmd_s[3] | (cmd_s[2:0] == dicc_pkg::CMD_NO_OP);

	// ************************************************************
	// command trace
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_seen <= 1'b0;
			cmd_code <= dicc_pkg::CMD_DES;
		end else begin
			cmd_seen <= rise;
			if (rise)
				cmd_code <= cmd_s[3] ? dicc_pkg::CMD_DES : cmd_s;
		end
	end

	// ************************************************************
	// power-down and bank state
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_pd       <= 1'b0;
			bank_open_q <= '0;
		end else if (rise) begin
			if (in_pd) begin
				if (cke_s)
					in_pd <= 1'b0;
			end else if (!cke_s) begin
				if (idle_cmd && bank_open_q == '0 && burst_cnt_q == '0)
					in_pd <= 1'b1;
			end else if (!cmd_s[3]) begin
				if (cmd_s[2:0] == dicc_pkg::CMD_ACT)
					bank_open_q[ba_s] <= 1'b1;
				if (cmd_s[2:0] == dicc_pkg::CMD_PRE) begin
					if (addr_s[dicc_pkg::ALL_BANKS_BIT])
						bank_open_q <= '0;
					else
						bank_open_q[ba_s] <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// bursts
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_cnt_q <= '0;
		end else if (rise) begin
			if (cke_s && !in_pd && !cmd_s[3] &&
			    (cmd_s[2:0] == dicc_pkg::CMD_RD || cmd_s[2:0] == dicc_pkg::CMD_WR))
				burst_cnt_q <= 4'(BURST_CK);
			else if (burst_cnt_q != '0)
				burst_cnt_q <= burst_cnt_q - 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			burst_busy <= 1'b0;
		else
			burst_busy <= burst_cnt_q != '0;
	end

	// ************************************************************
	// mode registers and dll
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q     <= '0;
			hts_sr     <= 1'b0;
			dll_locked <= 1'b1;
			lock_cnt_q <= '0;
		end else if (rise) begin
			if (!in_pd && !cke_s && idle_cmd && bank_open_q == '0 && burst_cnt_q == '0) begin
				dll_locked <= 1'b0;
				lock_cnt_q <= '0;
			end else if (cke_s && !in_pd && !cmd_s[3] && cmd_s[2:0] == dicc_pkg::CMD_MODE_WR) begin
				if (ba_s == dicc_pkg::BA_MR)
					mode_q <= addr_s;
				if (ba_s == dicc_pkg::BA_EMR2)
					hts_sr <= addr_s[dicc_pkg::HI_TEMP_SELF_REFRESH_BIT];
				if (ba_s == dicc_pkg::BA_EMR1 && addr_s[dicc_pkg::DLL_RST_BIT]) begin
					dll_locked <= 1'b0;
					lock_cnt_q <= 16'h0001;
				end
			end else if (lock_cnt_q != '0) begin
				if (lock_cnt_q == 16'(LOCK_CK)) begin
					dll_locked <= 1'b1;
					lock_cnt_q <= '0;
				end else begin
					lock_cnt_q <= lock_cnt_q + 16'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ready <= 1'b0;
		else
			ready <= dll_locked & ~in_pd & cke_s;
	end
endmodule

// *** core/dicc_ctrl.sv ***
// controller end: axi4-lite registers, clock divider, command sequencer
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - change clock only in precharge power-down
// - wait two clocks after clock enable low
// - new clock within speed-grade limits
// - termination and clock enable held low
// - stable new clock before power-down exit
// - reset dll by extended mode write
// - optional mode write for new latencies
// - termination off during dll relock
// - device normal after dll lock time
// - cs low, others high decodes no-op
// - no-op never stops running burst
// - controller sends no-ops when idle
// - cs high is deselect, others ignored
// - hot operation doubles refresh rate
// - extended register bit picks hot self-refresh
// - low enable with no-op enters power-down
// - dll off in precharge power-down
module dicc_ctrl #(
	parameter logic [7:0] CKDIV_MIN = 8'h02,
	parameter logic [7:0] CKDIV_MAX = 8'h08,
	parameter int         LOCK_CK   = dicc_pkg::LOCK_CK
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	dicc_link_if.ctl         link
);
	typedef enum logic [3:0] {
		S_IDLE, S_PRE, S_PDWAIT, S_FCHG, S_STAB, S_EXIT, S_EMR, S_MR, S_EMR2, S_RELOCK
	} dicc_state_e;

	function automatic logic [31:0] dicc_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	dicc_state_e  state_q;
	logic         aw_hold_q;
	logic         w_hold_q;
	logic [7:0]   awaddr_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	logic [4:1]   ctrl_q;
	logic [7:0]   ckdiv_q;
	logic [12:0]  mode_reg_q;
	logic         start_q;
	logic [31:0]  ctrl_m;
	logic [31:0]  ckdiv_m;
	logic [31:0]  mode_m;
	logic         wr_do;
	logic [7:0]   div_q;
	logic [7:0]   half_cnt_q;
	logic         fall;
	logic [15:0]  cnt_q;
	logic [15:0]  ref_cnt_q;
	logic         ref_due_q;

	assign wr_do   = aw_hold_q & w_hold_q & ~bvalid;
	assign ctrl_m  = dicc_merge({27'h0, ctrl_q, 1'b0}, wdata_q, wstrb_q);
	assign ckdiv_m = dicc_merge({24'h0, ckdiv_q}, wdata_q, wstrb_q);
	assign mode_m  = dicc_merge({19'h0, mode_reg_q}, wdata_q, wstrb_q);

	// ************************************************************
	// axi4-lite write channel
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid    <= 1'b0;
			bresp     <= dicc_pkg::RESP_OKAY;
		end else begin
			awready <= ~(awvalid & awready) & ~aw_hold_q & ~bvalid;
			wready  <= ~(wvalid & wready) & ~w_hold_q & ~bvalid;
			if (awvalid && awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			if (wr_do) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= dicc_pkg::RESP_OKAY;
				if (awaddr_q != dicc_pkg::REG_CTRL && awaddr_q != dicc_pkg::REG_CKDIV &&
				    awaddr_q != dicc_pkg::REG_MODE)
					bresp <= dicc_pkg::RESP_SLVERR;
				if (awaddr_q == dicc_pkg::REG_CKDIV &&
				    (ckdiv_m[7:0] < CKDIV_MIN || ckdiv_m[7:0] > CKDIV_MAX))
					bresp <= dicc_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q     <= '0;
			ckdiv_q    <= dicc_pkg::CKDIV_RST;
			mode_reg_q <= '0;
			start_q    <= 1'b0;
		end else begin
			if (state_q == S_PRE)
				start_q <= 1'b0;
			if (wr_do && awaddr_q == dicc_pkg::REG_CTRL) begin
				ctrl_q <= ctrl_m[4:1];
				if (ctrl_m[dicc_pkg::CTRL_START] && state_q == S_IDLE)
					start_q <= 1'b1;
			end
			if (wr_do && awaddr_q == dicc_pkg::REG_CKDIV &&
			    ckdiv_m[7:0] >= CKDIV_MIN && ckdiv_m[7:0] <= CKDIV_MAX)
				ckdiv_q <= ckdiv_m[7:0];
			if (wr_do && awaddr_q == dicc_pkg::REG_MODE)
				mode_reg_q <= mode_m[12:0];
		end
	end

	// ************************************************************
	// axi4-lite read channel
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= dicc_pkg::RESP_OKAY;
		end else begin
			arready <= ~(arvalid & arready) & ~rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= dicc_pkg::RESP_OKAY;
				unique case (araddr)
					dicc_pkg::REG_CTRL:   rdata <= {27'h0, ctrl_q, 1'b0};
					dicc_pkg::REG_CKDIV:  rdata <= {24'h0, ckdiv_q};
					dicc_pkg::REG_MODE:   rdata <= {19'h0, mode_reg_q};
					dicc_pkg::REG_STATUS: rdata <= {16'h0, div_q, 6'h0, ~link.cke,
					                                state_q != S_IDLE};
					default: begin
						rdata <= '0;
						rresp <= dicc_pkg::RESP_SLVERR;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// link clock divider
	// ************************************************************
	assign fall = (half_cnt_q == 8'h01) & link.ck;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.ck    <= 1'b0;
			half_cnt_q <= dicc_pkg::CKDIV_RST;
			div_q      <= dicc_pkg::CKDIV_RST;
		end else begin
			if (fall && state_q == S_FCHG)
				div_q <= ckdiv_q;
			if (half_cnt_q == 8'h01) begin
				link.ck    <= ~link.ck;
				half_cnt_q <= (fall && state_q == S_FCHG) ? ckdiv_q : div_q;
			end else begin
				half_cnt_q <= half_cnt_q - 8'h01;
			end
		end
	end

	// ************************************************************
	// refresh timer
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_cnt_q <= '0;
			ref_due_q <= 1'b0;
		end else begin
			if (fall && state_q == S_IDLE && ref_due_q)
				ref_due_q <= 1'b0;
			if (ref_cnt_q >= (ctrl_q[dicc_pkg::CTRL_HOT] ? 16'(dicc_pkg::REFI_HOT_CYC - 1)
			                                              : 16'(dicc_pkg::REFI_NORM_CYC - 1))) begin
				ref_cnt_q <= '0;
				ref_due_q <= 1'b1;
			end else begin
				ref_cnt_q <= ref_cnt_q + 16'h1;
			end
		end
	end

	// ************************************************************
	// command sequencer, updates on link clock fall
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= S_IDLE;
			cnt_q      <= '0;
			link.cke   <= 1'b1;
			link.on_die_termination_ctl <= 1'b0;
			{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dicc_pkg::CMD_DES;
			link.ba    <= '0;
			link.addr  <= '0;
		end else if (fall) begin
			{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_NO_OP};
			link.ba   <= '0;
			link.addr <= '0;
			link.on_die_termination_ctl <= ctrl_q[dicc_pkg::CTRL_TERM] && state_q == S_IDLE &&
			                               !start_q;
			cnt_q <= cnt_q + 16'h1;
			unique case (state_q)
				S_IDLE: begin
					cnt_q <= '0;
					if (ref_due_q) begin
						{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_REF};
					end else if (start_q) begin
						{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_PRE};
						link.addr[dicc_pkg::ALL_BANKS_BIT] <= 1'b1;
						state_q <= S_PRE;
					end
				end
				S_PRE: begin
					if (cnt_q == 16'(dicc_pkg::PRE_WAIT_CK - 1)) begin
						link.cke <= 1'b0;
						cnt_q    <= '0;
						state_q  <= S_PDWAIT;
					end
				end
				S_PDWAIT: begin
					if (cnt_q == 16'(dicc_pkg::PD_WAIT_CK - 1)) begin
						cnt_q   <= '0;
						state_q <= S_FCHG;
					end
				end
				S_FCHG: begin
					cnt_q   <= '0;
					state_q <= S_STAB;
				end
				S_STAB: begin
					if (cnt_q == 16'(dicc_pkg::STABLE_CK - 1)) begin
						link.cke <= 1'b1;
						state_q  <= S_EXIT;
					end
				end
				S_EXIT: begin
					{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_MODE_WR};
					link.ba <= dicc_pkg::BA_EMR1;
					link.addr[dicc_pkg::DLL_RST_BIT] <= 1'b1;
					state_q <= ctrl_q[dicc_pkg::CTRL_MRUPD] ? S_MR : S_EMR2;
				end
				S_MR: begin
					{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_MODE_WR};
					link.ba   <= dicc_pkg::BA_MR;
					link.addr <= mode_reg_q;
					state_q   <= S_EMR2;
				end
				S_EMR2: begin
					{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, dicc_pkg::CMD_MODE_WR};
					link.ba <= dicc_pkg::BA_EMR2;
					link.addr[dicc_pkg::HI_TEMP_SELF_REFRESH_BIT] <= ctrl_q[dicc_pkg::CTRL_HTS];
					cnt_q   <= '0;
					state_q <= S_RELOCK;
				end
				S_RELOCK: begin
					if (cnt_q == 16'(LOCK_CK))
						state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

// *** tb/dicc_asserts.sv ***
// link checker for idle commands and the clock-change sequence
`timescale 1ns/10ps
module dicc_asserts #(
	parameter logic [7:0] CKDIV_MIN = 8'h02,
	parameter logic [7:0] CKDIV_MAX = 8'h08,
	parameter int         LOCK_CK   = dicc_pkg::LOCK_CK
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        on_die_termination_ctl,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [12:0] addr
);
	// ************************************************************
	// helper logic
	// ************************************************************
	logic        ck_q;
	logic        cke_q;
	logic        wait_q;
	logic [7:0]  hp_q;
	logic [7:0]  last_q;
	logic [1:0]  tog_q;
	logic [15:0] low_q;
	logic [15:0] rel_q;
	logic        tog;
	logic        rise;
	logic        idle;
	assign tog  = ck != ck_q;
	assign rise = ck && !ck_q;
	assign idle = cs_n || {ras_n, cas_n, we_n} == 3'b111;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		ck_q  <= ck;
		cke_q <= cke;
	end
	// half-period length in clock cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hp_q   <= 8'h00;
			last_q <= 8'h00;
			tog_q  <= 2'h0;
		end else if (tog) begin
			hp_q   <= 8'h01;
			last_q <= hp_q;
			tog_q  <= tog_q + {1'b0, tog_q != 2'h3};
		end else begin
			hp_q <= hp_q + 8'h01;
		end
	end
	// link clock rises while clock enable is low
	always_ff @(posedge aclk) begin
		if (!aresetn || cke) begin
			low_q <= 16'h0000;
		end else if (rise) begin
			low_q <= low_q + 16'h0001;
		end
	end
	// link clock rises since power-down exit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rel_q  <= 16'h0000;
			wait_q <= 1'b0;
		end else if (cke && !cke_q) begin
			rel_q  <= 16'h0001;
			wait_q <= 1'b1;
		end else if (rise && rel_q != 16'h0000) begin
			rel_q  <= (rel_q >= LOCK_CK + 8) ? 16'h0000 : rel_q + 16'h0001;
			wait_q <= wait_q && idle;
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	a_term_pd_off: assert property (!cke |-> !on_die_termination_ctl)
		else $error("termination on while clock enable low");
	a_pd_entry_idle: assert property ($fell(cke) |-> idle)
		else $error("clock enable dropped with a real command");
	a_cmd_at_fall: assert property (ck && $past(ck)
		|-> $stable({cke, cs_n, ras_n, cas_n, we_n, ba, addr}))
		else $error("command changed while link clock high");
	a_div_in_range: assert property (tog && tog_q != 2'h0
		|-> hp_q inside {[CKDIV_MIN:CKDIV_MAX]})
		else $error("link clock half period out of range");
	a_div_change_pd: assert property (tog && tog_q > 2'h1 && hp_q != last_q
		|-> !cke && low_q >= 16'd2)
		else $error("clock rate changed outside power-down wait");
	a_stable_exit: assert property ($rose(cke) |-> low_q >= 16'd5)
		else $error("power-down left before new clock settled");
	a_dll_reset_cmd: assert property (rise && wait_q && !idle
		|-> !cs_n && {ras_n, cas_n, we_n} == dicc_pkg::CMD_MODE_WR && ba == dicc_pkg::BA_EMR1
		&& addr[dicc_pkg::DLL_RST_BIT])
		else $error("first command after exit is not a loop reset");
	a_dll_reset_soon: assert property (rel_q == 16'd4 |-> !wait_q)
		else $error("loop reset missing after exit");
	a_term_relock: assert property (rel_q != 16'd0 && rel_q <= LOCK_CK + 4
		|-> !on_die_termination_ctl)
		else $error("termination on during relock");
	a_relock_idle: assert property (rise && rel_q >= 16'd5 && rel_q <= LOCK_CK + 4
		|-> idle)
		else $error("command issued during relock");
endmodule

// *** tb/test_dicc.sv ***
// self-checking bench: controller and device end joined, plus a bench-driven device
`timescale 1ns/10ps
module test_dicc;
	localparam int LK = 8;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, ckq;
	logic        seen, inpd, lock, rdy, bsy, hts, seen2, inpd2, lock2, rdy2, bsy2, hts2;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, code, code2;
	logic [1:0]  bresp, rresp, r;
	logic [12:0] mode, mode2;
	int          err_total, n_tests, nref, nck, nlk;
	dicc_link_if i_dicc_link_if ();
	dicc_link_if i_dicc_link_if2 ();
	dicc_ctrl #(.LOCK_CK(LK)) i_dicc_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(i_dicc_link_if));
	dicc_mem #(.LOCK_CK(LK)) i_dicc_mem (.aclk(aclk), .aresetn(aresetn), .link(i_dicc_link_if),
		.cmd_seen(seen), .cmd_code(code), .in_pd(inpd), .dll_locked(lock), .ready(rdy),
		.burst_busy(bsy), .hts_sr(hts), .mode_q(mode));
	dicc_mem #(.LOCK_CK(LK), .BURST_CK(4)) i_dicc_mem2 (.aclk(aclk), .aresetn(aresetn),
		.link(i_dicc_link_if2), .cmd_seen(seen2), .cmd_code(code2), .in_pd(inpd2),
		.dll_locked(lock2), .ready(rdy2), .burst_busy(bsy2), .hts_sr(hts2), .mode_q(mode2));
	dicc_asserts #(.LOCK_CK(LK)) u_chk (.aclk(aclk), .aresetn(aresetn),
		.ck(i_dicc_link_if.ck), .cke(i_dicc_link_if.cke),
		.on_die_termination_ctl(i_dicc_link_if.on_die_termination_ctl),
		.cs_n(i_dicc_link_if.cs_n), .ras_n(i_dicc_link_if.ras_n), .cas_n(i_dicc_link_if.cas_n),
		.we_n(i_dicc_link_if.we_n), .ba(i_dicc_link_if.ba), .addr(i_dicc_link_if.addr));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// event counters on the joined link
	always @(posedge aclk) begin
		ckq <= i_dicc_link_if.ck;
		if (i_dicc_link_if.ck && !ckq) nck++;
		if (seen && code == 4'h1) nref++;
		if (seen && lock === 1'b0 && inpd === 1'b0) nlk++;
	end
	// ************************************************************
	// compare, access and link tasks
	// ************************************************************
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tmo(input string m);
		err_total++;
		$display("wrong value at %0t: %s timed out", $time, m);
		summarize();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
		chk({30'h0, got}, {30'h0, exp}, m);
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		int k;
		k = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && k < 100);
		bready <= 1'b0;
		if (k >= 100) tmo("write");
		chk_resp(bresp, e, "write response");
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		int k;
		k = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && k < 100);
		rready <= 1'b0;
		if (k >= 100) tmo("read");
		chk(rdata, v, "read data");
		chk_resp(rresp, e, "read response");
	endtask
	task automatic wait_on(input int s, input logic v);
		int k;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while ((s == 0 ? inpd : rdy) !== v && k < 4000);
		if (k >= 4000) tmo("device state");
	endtask
	// one command frame of 200 ns on the bench-driven link
	task automatic send(input logic e, input logic [3:0] c, input logic [12:0] a);
		{i_dicc_link_if2.cs_n, i_dicc_link_if2.ras_n} <= c[3:2];
		{i_dicc_link_if2.cas_n, i_dicc_link_if2.we_n} <= c[1:0];
		i_dicc_link_if2.cke  <= e;
		i_dicc_link_if2.addr <= a;
		repeat (4) @(posedge aclk);
		i_dicc_link_if2.ck <= 1'b1;
		repeat (4) @(posedge aclk);
		i_dicc_link_if2.ck <= 1'b0;
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{err_total, n_tests, nref, nck, nlk} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{i_dicc_link_if2.ck, i_dicc_link_if2.on_die_termination_ctl} = 2'b00;
		{i_dicc_link_if2.cke, i_dicc_link_if2.cs_n, i_dicc_link_if2.ras_n} = 3'b111;
		{i_dicc_link_if2.cas_n, i_dicc_link_if2.we_n, i_dicc_link_if2.ba} = 5'h18;
		i_dicc_link_if2.addr = 13'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(dicc_pkg::REG_CKDIV, 32'h2, dicc_pkg::RESP_OKAY);
		rchk(dicc_pkg::REG_STATUS, 32'h200, dicc_pkg::RESP_OKAY);
		rchk(8'h10, 32'h0, dicc_pkg::RESP_SLVERR);
		wchk(8'h10, 32'h5, dicc_pkg::RESP_SLVERR);
		wchk(dicc_pkg::REG_CKDIV, 32'h9, dicc_pkg::RESP_SLVERR);
		wchk(dicc_pkg::REG_CKDIV, 32'h1, dicc_pkg::RESP_SLVERR);
		rchk(dicc_pkg::REG_CKDIV, 32'h2, dicc_pkg::RESP_OKAY);
		chk({28'h0, code}, 32'h7, "idle command");
		nck = 0;
		repeat (160) @(posedge aclk);
		chk(32'(nck inside {[39:41]}), 32'h1, "old link rate");
		$display("test registers done");
		nref = 0;
		repeat (1560) @(posedge aclk);
		chk(32'(nref inside {[4:6]}), 32'h1, "normal refresh count");
		wchk(dicc_pkg::REG_CTRL, 32'h2, dicc_pkg::RESP_OKAY);
		nref = 0;
		repeat (1560) @(posedge aclk);
		chk(32'(nref inside {[9:11]}), 32'h1, "hot refresh count");
		$display("test refresh done");
		wchk(dicc_pkg::REG_MODE, 32'h123, dicc_pkg::RESP_OKAY);
		wchk(dicc_pkg::REG_CKDIV, 32'h4, dicc_pkg::RESP_OKAY);
		wchk(dicc_pkg::REG_CTRL, 32'h1d, dicc_pkg::RESP_OKAY);
		wait_on(0, 1'b1);
		chk(32'(lock), 32'h0, "loop off in power-down");
		chk(32'(i_dicc_link_if.cke), 32'h0, "clock enable low");
		chk(32'(i_dicc_link_if.on_die_termination_ctl), 32'h0, "termination low");
		nlk = 0;
		wait_on(1, 1'b1);
		chk(32'(nlk >= LK), 32'h1, "ready after lock time");
		chk({19'h0, mode}, 32'h123, "mode write issued");
		chk(32'(hts), 32'h1, "hot self-refresh bit");
		repeat (200) @(posedge aclk);
		rchk(dicc_pkg::REG_STATUS, 32'h400, dicc_pkg::RESP_OKAY);
		rchk(dicc_pkg::REG_CTRL, 32'h1c, dicc_pkg::RESP_OKAY);
		chk(32'(i_dicc_link_if.on_die_termination_ctl), 32'h1, "termination back on");
		nck = 0;
		repeat (160) @(posedge aclk);
		chk(32'(nck inside {[19:21]}), 32'h1, "new link rate");
		$display("test clock change done");
		send(1'b1, 4'h7, 13'h0);
		chk({28'h0, code2}, 32'h7, "no-op decode");
		send(1'b1, 4'h5, 13'h0);
		send(1'b1, 4'h7, 13'h0);
		chk(32'(bsy2), 32'h1, "burst kept by no-op");
		repeat (5) send(1'b1, 4'h7, 13'h0);
		chk(32'(bsy2), 32'h0, "burst finished");
		send(1'b1, 4'h8, 13'h1fff);
		chk({28'h0, code2}, 32'hf, "deselect decode");
		chk({19'h0, mode2}, 32'h0, "deselect ignores strobes");
		send(1'b0, 4'h7, 13'h0);
		chk(32'(inpd2), 32'h1, "power-down entry");
		chk(32'(lock2), 32'h0, "loop off");
		send(1'b1, 4'hf, 13'h0);
		chk(32'(inpd2), 32'h0, "power-down exit");
		$display("test device decode done");
		summarize();
	end
endmodule
